// *** rtl/sbcl_loader.sv ***
// Configuration loader: sequences a serial flash or takes a passive stream.
// Assumes a 50 MHz clk_i; all pins except resetn_i and word_ready_i are asynchronous and are synchronised here.
`include "sbcl_regs.svh"
module sbcl_loader (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic config_reset_n_i,
  input wire sbcl_pkg::sbcl_mode_t mode_i,
  input wire sbcl_pkg::sbcl_width_t width_i,
  input wire logic security_en_i,
  input wire logic clk_sel_ext_i,
  input wire logic external_config_clock_i,
  output logic flash_sclk_o,
  output logic flash_cs_n_o,
  output logic flash_mosi_o,
  output logic flash_mosi_oe_o,
  input wire logic [7:0] flash_data_i,
  input wire logic pass_clk_i,
  input wire logic pass_cs_n_i,
  input wire logic [31:0] pass_data_i,
  output logic pass_ready_o,
  output logic [31:0] word_o,
  output logic word_valid_o,
  input wire logic word_ready_i,
  output logic busy_o,
  output logic refused_o
);
  import sbcl_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int SW = 51;
  logic [SW-1:0] pins_w; // Raw pin vector
  logic [SW-1:0] sync1_reg; // First stage, read only by second stage
  logic [SW-1:0] sync2_reg; // Second stage, safe to use
  logic cfg_prev_reg; // Previous reset level for edge finding
  logic ext_prev_reg; // Previous external clock level
  logic pclk_prev_reg; // Previous passive clock level
  assign pins_w = {config_reset_n_i, external_config_clock_i, pass_clk_i, pass_cs_n_i,
                   flash_data_i, pass_data_i, mode_i, width_i, security_en_i, clk_sel_ext_i};

  // Two flops per pin, plus edge history
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      cfg_prev_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      pclk_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pins_w;
      sync2_reg <= sync1_reg;
      cfg_prev_reg <= sync2_reg[50];
      ext_prev_reg <= sync2_reg[49];
      pclk_prev_reg <= sync2_reg[48];
    end
  end

  // Synchronised views
  logic cfg_n_s;
  logic cfg_rise;
  logic ext_rise;
  logic pclk_rise;
  logic pcs_n_s;
  logic [7:0] fdata_s;
  logic [31:0] pdata_s;
  sbcl_mode_t mode_s;
  sbcl_width_t width_s;
  logic sec_s;
  logic csel_s;
  assign cfg_n_s = sync2_reg[50];
  assign cfg_rise = cfg_n_s & ~cfg_prev_reg;
  assign ext_rise = sync2_reg[49] & ~ext_prev_reg;
  assign pclk_rise = sync2_reg[48] & ~pclk_prev_reg;
  assign pcs_n_s = sync2_reg[47];
  assign fdata_s = sync2_reg[46:39];
  assign pdata_s = sync2_reg[38:7];
  assign mode_s = sbcl_mode_t'(sync2_reg[6:5]);
  assign width_s = sbcl_width_t'(sync2_reg[4:2]);
  assign sec_s = sync2_reg[1];
  assign csel_s = sync2_reg[0];

  // Beats per 32-bit word minus one for a width code
  function automatic logic [5:0] last_beat(input sbcl_width_t w);
    last_beat = 6'(6'h20 >> w) - 6'h01;
  endfunction

  // ************************************************************
  // Two-entry word buffer
  // ************************************************************
  logic [31:0] buf_mem [2]; // Storage
  logic [31:0] buf_mem_next [2];
  logic [1:0] cnt_reg; // Words held
  logic [1:0] cnt_next;
  logic rd_reg; // Read pointer
  logic rd_next;
  logic push_reg; // Word ready to enqueue
  logic [31:0] acc_reg; // Word assembler
  logic in_ready;
  logic pop;
  assign in_ready = (cnt_reg != 2'h2);
  assign pop = word_valid_o & word_ready_i;
  assign word_valid_o = (cnt_reg != 2'h0);
  assign word_o = buf_mem[rd_reg];
  assign pass_ready_o = in_ready;

  // Next buffer state: write at rd+cnt, read at rd
  always_comb begin
    buf_mem_next = buf_mem;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    if (push_reg && in_ready) begin
      buf_mem_next[rd_reg ^ cnt_reg[0]] = acc_reg;
    end
    if (pop) begin
      rd_next = ~rd_reg;
    end
    cnt_next = 2'(cnt_reg + {1'b0, push_reg & in_ready} - {1'b0, pop});
  end

  // Register buffer state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      buf_mem[0] <= 32'h00000000;
      buf_mem[1] <= 32'h00000000;
      cnt_reg <= 2'h0;
      rd_reg <= 1'b0;
    end else begin
      buf_mem <= buf_mem_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
    end
  end

  // ************************************************************
  // Configuration sequencer
  // ************************************************************
  sbcl_state_t state_reg, state_next;
  sbcl_width_t width_reg, width_next; // Width caught at reset release
  logic csel_reg, csel_next; // Clock source caught at reset release
  logic [10:0] wait_reg, wait_next; // Wait counter
  logic [5:0] bit_reg, bit_next; // Command bit or word beat index
  logic [39:0] shift_reg, shift_next; // Outgoing command frame
  logic [31:0] acc_next;
  logic push_next;
  logic sclk_reg, sclk_next;
  logic cs_n_reg, cs_n_next;
  logic mosi_reg, mosi_next;
  logic [1:0] div_reg, div_next; // Oscillator divider
  logic tick; // Serial clock half-period enable
  logic sample; // Take one beat into the assembler
  logic [31:0] din;
  logic [31:0] mask;
  logic [5:0] nb;

  assign tick = csel_reg ? ext_rise : (div_reg == 2'(`SBCL_OSC_DIV - 1));
  assign nb = 6'(6'h01 << width_reg);
  assign mask = (width_reg == SBCL_X32) ? 32'hffffffff : 32'((33'h1 << nb) - 33'h1);

  // Next sequencer state
  always_comb begin
    state_next = state_reg;
    width_next = width_reg;
    csel_next = csel_reg;
    wait_next = wait_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    acc_next = acc_reg;
    push_next = 1'b0;
    sclk_next = sclk_reg;
    cs_n_next = cs_n_reg;
    mosi_next = mosi_reg;
    div_next = (div_reg == 2'(`SBCL_OSC_DIV - 1)) ? 2'h0 : 2'(div_reg + 2'h1);
    sample = 1'b0;
    din = 32'h00000000;
    if (!cfg_n_s) begin
      // Held idle and deaf while reset pin low
      state_next = SBCL_IDLE;
      sclk_next = 1'b0;
      cs_n_next = 1'b1;
      mosi_next = 1'b0;
    end else begin
      case (state_reg)
        SBCL_IDLE: begin
          if (cfg_rise) begin
            width_next = width_s;
            csel_next = csel_s;
            wait_next = 11'h000;
            bit_next = 6'h00;
            acc_next = 32'h00000000;
            if (mode_s == SBCL_MODE_ACTIVE && width_s <= SBCL_X8) begin
              // Start by waking the flash
              state_next = SBCL_WAKE_CMD;
              shift_next = {`SBCL_WAKE_OP, 32'h00000000};
              cs_n_next = 1'b0;
              mosi_next = shift_next[39];
            end else if (mode_s == SBCL_MODE_PASSIVE) begin
              // Secured images may not use the wide passive port
              if (sec_s && width_s >= SBCL_X16) begin
                state_next = SBCL_REFUSED;
              end else if (width_s <= SBCL_X32) begin
                state_next = SBCL_PASS_WAIT;
              end else begin
                state_next = SBCL_REFUSED;
              end
            end else if (mode_s != SBCL_MODE_JTAG) begin
              // Unsupported width or mode; scan loads elsewhere
              state_next = SBCL_REFUSED;
            end
          end
        end
        SBCL_WAKE_CMD, SBCL_READ_CMD: begin
          // Shift a command frame MSB first, flash samples on rising edge
          if (tick) begin
            if (!sclk_reg) begin
              sclk_next = 1'b1;
            end else begin
              sclk_next = 1'b0;
              shift_next = {shift_reg[38:0], 1'b0};
              mosi_next = shift_reg[38];
              bit_next = 6'(bit_reg + 6'h01);
              if (state_reg == SBCL_WAKE_CMD && bit_reg == `SBCL_WAKE_LAST) begin
                state_next = SBCL_WAKE_GAP;
                cs_n_next = 1'b1;
                wait_next = 11'h000;
              end else if (state_reg == SBCL_READ_CMD && bit_reg == `SBCL_READ_LAST) begin
                state_next = SBCL_READ_DATA;
                bit_next = 6'h00;
              end
            end
          end
        end
        SBCL_WAKE_GAP: begin
          // Flash needs time to leave power-down
          wait_next = 11'(wait_reg + 11'h001);
          if (wait_reg == 11'(`SBCL_WAKE_CYC - 1)) begin
            state_next = SBCL_READ_CMD;
            shift_next = {`SBCL_READ_OP, `SBCL_START_ADDR, 8'h00};
            mosi_next = shift_next[39];
            cs_n_next = 1'b0;
            bit_next = 6'h00;
          end
        end
        SBCL_READ_DATA: begin
          // Clock stops while the buffer is full, so no word is lost
          if (tick && in_ready) begin
            sclk_next = ~sclk_reg;
            sample = ~sclk_reg;
            din = {24'h000000, fdata_s};
          end
        end
        SBCL_PASS_WAIT: begin
          // Ignore passive pins during the lead-in
          wait_next = 11'(wait_reg + 11'h001);
          if (wait_reg == 11'(`SBCL_PASS_CYC - 1)) begin
            state_next = SBCL_PASS_DATA;
          end
        end
        SBCL_PASS_DATA: begin
          // Master clocks data; beats taken on its rising edge
          sample = pclk_rise & ~pcs_n_s;
          din = pdata_s;
        end
        default: begin
          // Refused: wait for the next reset cycle
        end
      endcase
      if (sample) begin
        acc_next = (acc_reg << nb) | (din & mask);
        bit_next = 6'(bit_reg + 6'h01);
        if (bit_reg == last_beat(width_reg)) begin
          push_next = 1'b1;
          bit_next = 6'h00;
        end
      end
    end
  end

  // Register sequencer state
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= SBCL_IDLE;
      width_reg <= SBCL_X1;
      csel_reg <= 1'b0;
      wait_reg <= 11'h000;
      bit_reg <= 6'h00;
      shift_reg <= 40'h0000000000;
      acc_reg <= 32'h00000000;
      push_reg <= 1'b0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
      div_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      width_reg <= width_next;
      csel_reg <= csel_next;
      wait_reg <= wait_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      acc_reg <= acc_next;
      push_reg <= push_next;
      sclk_reg <= sclk_next;
      cs_n_reg <= cs_n_next;
      mosi_reg <= mosi_next;
      div_reg <= div_next;
    end
  end

  // Pin and status outputs
  assign flash_sclk_o = sclk_reg;
  assign flash_cs_n_o = cs_n_reg;
  assign flash_mosi_o = mosi_reg;
  assign flash_mosi_oe_o = (state_reg == SBCL_WAKE_CMD) || (state_reg == SBCL_READ_CMD);
  assign busy_o = (state_reg != SBCL_IDLE) && (state_reg != SBCL_REFUSED);
  assign refused_o = (state_reg == SBCL_REFUSED);

  // ************************************************************
  // Checks
  // ************************************************************
  a_idle_in_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !cfg_n_s |=> state_reg == SBCL_IDLE && flash_cs_n_o) else $error("not idle in reset");
  a_active_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_reg == SBCL_IDLE && cfg_n_s && cfg_rise && mode_s == SBCL_MODE_ACTIVE && width_s <= SBCL_X8
    |=> state_reg == SBCL_WAKE_CMD && !flash_cs_n_o) else $error("active load did not start");
  a_wake_wait: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_reg == SBCL_READ_CMD && $past(state_reg) == SBCL_WAKE_GAP
    |-> $past(wait_reg) == 11'(`SBCL_WAKE_CYC - 1)) else $error("wake wait too short");
  a_addr_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_reg == SBCL_READ_CMD && bit_reg >= 6'h08 && flash_sclk_o |-> !flash_mosi_o)
    else $error("nonzero start address");
  a_clk_source: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cfg_n_s && $changed(flash_sclk_o) |-> $past(tick)) else $error("serial clock moved without tick");
  a_width_active: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_reg == SBCL_READ_DATA |-> width_reg <= SBCL_X8) else $error("active width above x8");
  a_secure_refuse: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_reg == SBCL_IDLE && cfg_n_s && cfg_rise && mode_s == SBCL_MODE_PASSIVE && sec_s
    && width_s >= SBCL_X16 |=> refused_o ##1 refused_o) else $error("secured wide passive accepted");
  a_pass_lead: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state_reg == SBCL_PASS_WAIT |=> !push_reg) else $error("data taken during lead-in");
  a_buf_full: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cnt_reg == 2'h2 && !word_ready_i |=> cnt_reg == 2'h2 && !pass_ready_o) else $error("buffer overrun");
endmodule // sbcl_loader

// *** shared/sbcl_pkg.sv ***
// Types shared by the configuration loader.
// Assumes nothing beyond a SystemVerilog compiler.
package sbcl_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    SBCL_IDLE = 3'b000,
    SBCL_WAKE_CMD = 3'b001,
    SBCL_WAKE_GAP = 3'b010,
    SBCL_READ_CMD = 3'b011,
    SBCL_READ_DATA = 3'b100,
    SBCL_PASS_WAIT = 3'b101,
    SBCL_PASS_DATA = 3'b110,
    SBCL_REFUSED = 3'b111
  } sbcl_state_t;
  // Configuration modes
  typedef enum logic [1:0] {
    SBCL_MODE_ACTIVE = 2'b00,
    SBCL_MODE_PASSIVE = 2'b01,
    SBCL_MODE_JTAG = 2'b10
  } sbcl_mode_t;
  // Data widths, log2 of bits per beat
  typedef enum logic [2:0] {
    SBCL_X1 = 3'b000,
    SBCL_X2 = 3'b001,
    SBCL_X4 = 3'b010,
    SBCL_X8 = 3'b011,
    SBCL_X16 = 3'b100,
    SBCL_X32 = 3'b101
  } sbcl_width_t;
endpackage

// *** shared/sbcl_regs.svh ***
// Timing counts, opcodes and start address of the configuration loader.
// Assumes a 50 MHz system clock; included by its bare name.
`ifndef SBCL_REGS_SVH
`define SBCL_REGS_SVH
// System clock rate in MHz
`define SBCL_CLK_MHZ 50
// Flash wake-up wait, least time in microseconds, and its cycle count
`define SBCL_WAKE_US 30
`define SBCL_WAKE_CYC (`SBCL_WAKE_US * `SBCL_CLK_MHZ)
// Passive lead-in wait after reset release, microseconds, and cycles
`define SBCL_PASS_US 32
`define SBCL_PASS_CYC (`SBCL_PASS_US * `SBCL_CLK_MHZ)
// Internal oscillator divider: serial clock ticks every this many cycles
`define SBCL_OSC_DIV 4
// Flash instructions and start address
`define SBCL_WAKE_OP 8'hab
`define SBCL_READ_OP 8'h0b
`define SBCL_START_ADDR 24'h000000
// Last bit index of the wake and read command frames
`define SBCL_WAKE_LAST 6'h07
`define SBCL_READ_LAST 6'h27
`endif

// *** test/sbcl_flash_model.sv ***
// Serial flash stand-in: records the wake and read frames, times the gap
// between them and serves a byte stream that rises by one each beat.
// Assumes sclk idles low, bits taken on sclk rise, data moved on sclk fall.
module sbcl_flash_model (
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic [7:0] data_o,
  output logic [7:0] wake_o,
  output logic [39:0] read_o,
  output int gap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_cnt; // Bits seen in the current frame
  int frame_no; // 0 wake frame, 1 read frame
  realtime t_rise; // End of the last frame
  logic [7:0] beat; // Next byte to serve
  initial begin
    data_o = 8'h5a;
    wake_o = 8'h00;
    read_o = 40'h0;
    gap_o = 0;
    bit_cnt = 0;
    frame_no = 0;
    beat = 8'h10;
  end
  // A fresh load starts from the wake frame again
  always @(posedge rst_n_i) begin
    frame_no = 0;
    beat = 8'h10;
  end
  // Frame start: time the quiet gap before the read frame
  always @(negedge cs_n_i) begin
    bit_cnt = 0;
    if (frame_no == 1) gap_o = int'($realtime - t_rise);
  end
  // Frame end: released line no longer shows the last value
  always @(posedge cs_n_i) begin
    frame_no++;
    t_rise = $realtime;
    data_o = ~data_o;
  end
  // Command bits arrive most significant first
  always @(posedge sclk_i) if (!cs_n_i) begin
    if (frame_no == 0 && bit_cnt < 8) wake_o = {wake_o[6:0], mosi_i};
    if (frame_no == 1 && bit_cnt < 40) read_o = {read_o[38:0], mosi_i};
    bit_cnt++;
  end
  // Data follows the 40 command bits; before that the line wanders
  always @(negedge sclk_i) if (!cs_n_i) begin
    if (frame_no == 1 && bit_cnt >= 40) begin
      data_o = beat;
      beat++;
    end else begin
      data_o = ~data_o;
    end
  end
endmodule // sbcl_flash_model

// *** test/tb_sbcl_loader.sv ***
// Bench for the configuration loader: active load with a flash model,
// external serial clock, passive stream and the refused strap sets.
// Assumes sbcl_pkg and the flash model are compiled first.
`include "sbcl_regs.svh"
module tb_sbcl_loader;
  timeunit 1ns;
  timeprecision 1ps;
  import sbcl_pkg::*;
  localparam int EXT_NS = 160; // Half period of the external clock is 80 ns
  logic clk_i, resetn_i, cfg_n, sec, ext_sel, ext_clk, pclk, pcs_n, wrdy;
  logic sclk, cs_n, mosi, oe, prdy, wvalid, busy, refused;
  sbcl_mode_t mode;
  sbcl_width_t width;
  logic [31:0] pdata, word;
  logic [7:0] fdata, wake;
  logic [39:0] rd_bits;
  int gap, failures, compares;
  realtime t0;
  sbcl_loader sbcl_loader_inst (.clk_i(clk_i), .resetn_i(resetn_i), .config_reset_n_i(cfg_n),
    .mode_i(mode), .width_i(width), .security_en_i(sec), .clk_sel_ext_i(ext_sel),
    .external_config_clock_i(ext_clk), .flash_sclk_o(sclk), .flash_cs_n_o(cs_n),
    .flash_mosi_o(mosi), .flash_mosi_oe_o(oe), .flash_data_i(fdata), .pass_clk_i(pclk),
    .pass_cs_n_i(pcs_n), .pass_data_i(pdata), .pass_ready_o(prdy), .word_o(word),
    .word_valid_o(wvalid), .word_ready_i(wrdy), .busy_o(busy), .refused_o(refused));
  sbcl_flash_model sbcl_flash_model_inst (.rst_n_i(cfg_n), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .data_o(fdata), .wake_o(wake), .read_o(rd_bits), .gap_o(gap));
  // ******************************
  // Clocks
  // ******************************
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  // External clock runs free, phase unrelated to clk_i
  initial begin
    ext_clk = 0;
    #7;
    forever #(EXT_NS / 2) ext_clk = ~ext_clk;
  end
  // ******************************
  // Shared tasks
  // ******************************
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Pull the reset pin low, set straps, release it
  task automatic restart(sbcl_mode_t m, sbcl_width_t w, logic s, logic e);
    @(posedge clk_i) #1 cfg_n = 0;
    mode = m;
    width = w;
    sec = s;
    ext_sel = e;
    repeat (6) @(posedge clk_i);
    #1 check("busy in reset", 0, busy);
    check("select in reset", 1, cs_n);
    check("enable in reset", 0, oe);
    cfg_n = 1;
  endtask
  // Wait for the flash select to reach a level
  task automatic wait_for(logic lvl);
    int n;
    n = 0;
    while (cs_n !== lvl && n < 5000) begin
      @(posedge clk_i) #1;
      n++;
    end
    check("select level", lvl, cs_n);
  endtask
  // One passive beat: data set a cycle apart from the last change, held over both clock phases
  task automatic beat(logic [31:0] d);
    @(posedge clk_i) #1 pdata = d;
    repeat (3) @(posedge clk_i);
    #1 pclk = 1;
    repeat (3) @(posedge clk_i);
    #1 pclk = 0;
    pdata = ~d;
  endtask
  // Take one word from the output buffer
  task automatic pop(logic [31:0] exp);
    int n;
    n = 0;
    @(posedge clk_i) #1;
    while (wvalid !== 1'b1 && n < 2000) begin
      @(posedge clk_i) #1;
      n++;
    end
    check("valid", 1, wvalid);
    check("word", exp, word);
    wrdy = 1;
    @(posedge clk_i) #1 wrdy = 0;
  endtask
  // ******************************
  // Scenarios
  // ******************************
  task automatic test_active;
    restart(SBCL_MODE_ACTIVE, SBCL_X8, 1'h0, 1'h0);
    wait_for(0);
    check("busy", 1, busy);
    check("drive enable", 1, oe);
    @(posedge sclk) t0 = $realtime;
    @(posedge sclk) check("serial period", 2 * `SBCL_OSC_DIV * 20, int'($realtime - t0));
    wait_for(1);
    check("wake op", `SBCL_WAKE_OP, wake);
    check("drive released", 0, oe);
    wait_for(0);
    check("gap long enough", 1, gap >= `SBCL_WAKE_US * 1000);
    repeat (600) @(posedge clk_i);
    #1 check("read frame", {`SBCL_READ_OP, `SBCL_START_ADDR}, rd_bits[39:8]);
    check("dummy bits", 0, rd_bits[7:0]);
    check("drive idle", 0, oe);
    check("buffer full", 0, prdy);
    pop(32'h10111213);
    pop(32'h14151617);
    pop(32'h18191a1b);
    $display("active load test done");
  endtask
  task automatic test_ext_clock;
    restart(SBCL_MODE_ACTIVE, SBCL_X1, 1'h0, 1'h1);
    wait_for(0);
    @(posedge sclk) t0 = $realtime;
    @(posedge sclk) check("serial period", 2 * EXT_NS, int'($realtime - t0));
    wait_for(1);
    check("wake op", `SBCL_WAKE_OP, wake);
    $display("external clock test done");
  endtask
  task automatic test_passive;
    restart(SBCL_MODE_PASSIVE, SBCL_X16, 1'h0, 1'h0);
    pcs_n = 0;
    beat(32'h0000dead);
    repeat (1700) @(posedge clk_i);
    #1 check("room", 1, prdy);
    beat(32'h00001234);
    beat(32'h00005678);
    pop(32'h12345678);
    // Narrow port: eight nibbles, upper lines set to show they are masked
    restart(SBCL_MODE_PASSIVE, SBCL_X4, 1'h0, 1'h0);
    repeat (1700) @(posedge clk_i);
    for (int i = 1; i < 9; i++) beat(32'hfffffff0 | 32'(i));
    pop(32'h12345678);
    pcs_n = 1;
    $display("passive load test done");
  endtask
  // Strap sets and whether each is refused
  task automatic test_modes;
    sbcl_mode_t m [7] = '{SBCL_MODE_PASSIVE, SBCL_MODE_PASSIVE, SBCL_MODE_ACTIVE, SBCL_MODE_JTAG,
      sbcl_mode_t'(2'b11), SBCL_MODE_PASSIVE, SBCL_MODE_ACTIVE};
    sbcl_width_t w [7] = '{SBCL_X32, SBCL_X16, SBCL_X16, SBCL_X1, SBCL_X1, SBCL_X32, SBCL_X8};
    logic s [7] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
    logic r [7] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
    for (int i = 0; i < 7; i++) begin
      restart(m[i], w[i], s[i], 1'h0);
      repeat (10) @(posedge clk_i);
      #1 check("refused", r[i], refused);
      check("busy", !r[i] && m[i] != SBCL_MODE_JTAG, busy);
    end
    $display("mode table test done");
  endtask
  // ******************************
  // Main sequence and watchdog
  // ******************************
  initial begin
    resetn_i = 0;
    cfg_n = 0;
    sec = 0;
    ext_sel = 0;
    pclk = 0;
    pcs_n = 1;
    pdata = 32'h0;
    wrdy = 0;
    mode = SBCL_MODE_ACTIVE;
    width = SBCL_X1;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge clk_i);
    #1 resetn_i = 1;
    test_active();
    test_ext_clock();
    test_passive();
    test_modes();
    close_out();
  end
  // About 6000 cycles are expected; a hang is cut off well beyond
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    close_out();
  end
endmodule // tb_sbcl_loader
